// *** core/ioc_defines.svh ***
// Register indices, field positions, reset values and rule overview for the I/O, CRC, ECC and ID bank.
// Overview of operation
// [RULE1] Output pin follows its latch bit level.
// [RULE2] Standby pin driven only while enable set.
// [RULE3] Direction bit one is input, zero output.
// [RULE4] Mode select zero forces pin to output.
// [RULE5] Host writes pin control one byte each.
// [RULE6] Byte count mismatch sets sticky format flag.
// [RULE7] Checksum mismatch sets sticky check flag.
// [RULE8] RAM correction applied only while enabled.
// [RULE9] Separate interrupt enables for single, double errors.
// [RULE10] Single and double error flags, hardware set.
// [RULE11] Identity register: revision low, identifier high.
// [RULE12] Unimplemented bits read zero, ignore writes.
// [RULE13] Capture failing address and mismatching checksum value.
// [RULE14] Parity override written to RAM when disabled.
// [RULE15] Interrupt when any enabled error flag set.
`ifndef IOC_DEFINES_SVH
`define IOC_DEFINES_SVH

`define IOC_IDX_PIN_IO        3'h0
`define IOC_IDX_CRC_STAT      3'h1
`define IOC_IDX_ECC_CTRL      3'h2
`define IOC_IDX_ECC_STAT      3'h3
`define IOC_IDX_PART_ID       3'h4

`define IOC_POS_DIR0          0
`define IOC_POS_DIR1          1
`define IOC_POS_STBY_EN       6
`define IOC_POS_LEVEL0        8
`define IOC_POS_LEVEL1        9
`define IOC_POS_PIN0_IN       16
`define IOC_POS_PIN1_IN       17
`define IOC_POS_MODE0         24
`define IOC_POS_MODE1         25

`define IOC_POS_CRC_VAL_LO    0
`define IOC_POS_CRC_FLAG      16
`define IOC_POS_FMT_FLAG      17
`define IOC_POS_CRC_IE        24
`define IOC_POS_FMT_IE        25

`define IOC_POS_ECC_EN        0
`define IOC_POS_SEC_IE        1
`define IOC_POS_DED_IE        2
`define IOC_POS_PARITY_LO     8
`define IOC_POS_SEC_FLAG      1
`define IOC_POS_DED_FLAG      2
`define IOC_POS_FAIL_ADDR_LO  16

`define IOC_POS_REV_LO        0
`define IOC_POS_ID_LO         4

`define IOC_RST_DIR           2'h3
`define IOC_RST_PM            2'h3
`define IOC_RST_LAT           2'h0
`define IOC_RST_STBY_EN       1'h0
`define IOC_RST_PARITY        7'h00

`endif

// *** core/ioc_pin_ctrl.sv ***
// One general-purpose pin: output drive, output enable and synchronised input level.
`timescale 1ns/1ps
module ioc_pin_ctrl (
   input  wire logic clk_sys_i,
   input  wire logic rstn_i,
   input  wire logic level_i,
   input  wire logic dir_i,
   input  wire logic mode_i,
   input  wire logic pin_i,
   output logic      pin_o,
   output logic      pin_oe_o,
   output logic      pin_level_o
);
   logic sync_meta_reg;

   // Mode zero overrides the direction bit, so the pin drives regardless.
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         pin_oe_o <= 1'b0;
         pin_o    <= 1'b0;
      end else begin
         pin_oe_o <= !mode_i || !dir_i; // [RULE3] [RULE4]
         pin_o    <= level_i;           // [RULE1]
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         sync_meta_reg <= 1'b0;
         pin_level_o   <= 1'b0;
      end else begin
         sync_meta_reg <= pin_i;
         pin_level_o   <= sync_meta_reg;
      end
   end
endmodule

// *** core/ioc_pkg.sv ***
// Types shared by the I/O, CRC, ECC and ID register bank.
package ioc_pkg;
   typedef logic [2:0]  ioc_reg_idx_t;
   typedef logic [31:0] ioc_word_t;
   typedef logic [3:0]  ioc_byte_en_t;
   typedef logic [11:0] ioc_ram_addr_t;
   typedef logic [15:0] ioc_crc_t;
   typedef logic [6:0]  ioc_parity_t;
endpackage

// *** core/ioc_reg_bank.sv ***
// Register bank for pin control, command checksum errors, RAM ECC control and status, and identity.
`timescale 1ns/1ps
`include "ioc_defines.svh"
module ioc_reg_bank #(
   parameter logic [3:0] PART_ID  = 4'h5, // Arbitrary value.
   parameter logic [3:0] PART_REV = 4'h2  // Arbitrary value.
) (
   input  wire logic                  clk_sys_i,
   input  wire logic                  rstn_i,
   input  wire logic                  reg_wr_i,
   input  wire logic                  reg_rd_i,
   input  wire ioc_pkg::ioc_reg_idx_t reg_idx_i,
   input  wire ioc_pkg::ioc_byte_en_t reg_be_i,
   input  wire ioc_pkg::ioc_word_t    reg_wdata_i,
   output ioc_pkg::ioc_word_t         reg_rdata_o,
   output logic                       reg_rvalid_o,
   input  wire logic                  cmd_format_err_i,
   input  wire logic                  spi_check_err_i,
   input  wire ioc_pkg::ioc_crc_t     spi_check_value_i,
   input  wire logic                  single_err_i,
   input  wire logic                  double_err_i,
   input  wire ioc_pkg::ioc_ram_addr_t err_addr_i,
   input  wire logic                  standby_request_i,
   input  wire logic [1:0]            general_pin_i,
   output logic [1:0]                 general_pin_o,
   output logic [1:0]                 general_pin_oe_o,
   output logic                       transceiver_standby_pin_o,
   output logic                       transceiver_standby_pin_oe_o,
   output logic                       ram_correction_enable_o,
   output logic                       parity_override_enable_o,
   output ioc_pkg::ioc_parity_t       parity_override_o,
   output logic                       irq_o
);
   import ioc_pkg::*;

   logic [1:0]    pin_direction_reg;
   logic [1:0]    pin_output_level_reg;
   logic [1:0]    pin_mode_select_reg;
   logic          standby_pin_ctrl_enable_reg;
   logic [1:0]    pin_level_sync;
   logic          cmd_format_err_irq_enable_reg;
   logic          spi_check_err_irq_enable_reg;
   logic          cmd_format_err_flag;
   logic          spi_check_err_flag;
   ioc_crc_t      spi_check_value_reg;
   logic          ram_correction_enable_reg;
   logic          single_err_irq_enable_reg;
   logic          double_err_irq_enable_reg;
   ioc_parity_t   parity_reg;
   logic          single_err_flag;
   logic          double_err_flag;
   ioc_ram_addr_t failing_ram_address_reg;
   ioc_word_t     rdata_next;

   logic wr_pin_io;
   logic wr_crc;
   logic wr_ecc_ctrl;
   logic wr_ecc_stat;
   logic clr_fmt;
   logic clr_crc;
   logic clr_sec;
   logic clr_ded;

   assign wr_pin_io   = reg_wr_i && (reg_idx_i == `IOC_IDX_PIN_IO);
   assign wr_crc      = reg_wr_i && (reg_idx_i == `IOC_IDX_CRC_STAT);
   assign wr_ecc_ctrl = reg_wr_i && (reg_idx_i == `IOC_IDX_ECC_CTRL);
   assign wr_ecc_stat = reg_wr_i && (reg_idx_i == `IOC_IDX_ECC_STAT);

   // Flags clear when software writes a zero into them; a one leaves them alone.
   assign clr_fmt = wr_crc && reg_be_i[2] && !reg_wdata_i[`IOC_POS_FMT_FLAG];
   assign clr_crc = wr_crc && reg_be_i[2] && !reg_wdata_i[`IOC_POS_CRC_FLAG];
   assign clr_sec = wr_ecc_stat && reg_be_i[0] && !reg_wdata_i[`IOC_POS_SEC_FLAG];
   assign clr_ded = wr_ecc_stat && reg_be_i[0] && !reg_wdata_i[`IOC_POS_DED_FLAG];

   // Each byte lane is written on its own, so a one-byte write never disturbs its neighbours.
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         pin_direction_reg           <= `IOC_RST_DIR;
         standby_pin_ctrl_enable_reg <= `IOC_RST_STBY_EN;
         pin_output_level_reg        <= `IOC_RST_LAT;
         pin_mode_select_reg         <= `IOC_RST_PM;
      end else if (wr_pin_io) begin
         if (reg_be_i[0]) begin // [RULE5]
            pin_direction_reg           <= {reg_wdata_i[`IOC_POS_DIR1], reg_wdata_i[`IOC_POS_DIR0]}; // [RULE3]
            standby_pin_ctrl_enable_reg <= reg_wdata_i[`IOC_POS_STBY_EN]; // [RULE2]
         end
         if (reg_be_i[1]) begin
            pin_output_level_reg <= {reg_wdata_i[`IOC_POS_LEVEL1], reg_wdata_i[`IOC_POS_LEVEL0]}; // [RULE1]
         end
         if (reg_be_i[3]) begin
            pin_mode_select_reg <= {reg_wdata_i[`IOC_POS_MODE1], reg_wdata_i[`IOC_POS_MODE0]}; // [RULE4]
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         cmd_format_err_irq_enable_reg <= 1'b0;
         spi_check_err_irq_enable_reg  <= 1'b0;
      end else if (wr_crc && reg_be_i[3]) begin
         cmd_format_err_irq_enable_reg <= reg_wdata_i[`IOC_POS_FMT_IE];
         spi_check_err_irq_enable_reg  <= reg_wdata_i[`IOC_POS_CRC_IE];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         ram_correction_enable_reg <= 1'b0;
         single_err_irq_enable_reg <= 1'b0;
         double_err_irq_enable_reg <= 1'b0;
         parity_reg                <= `IOC_RST_PARITY;
      end else if (wr_ecc_ctrl) begin
         if (reg_be_i[0]) begin
            ram_correction_enable_reg <= reg_wdata_i[`IOC_POS_ECC_EN];  // [RULE8]
            single_err_irq_enable_reg <= reg_wdata_i[`IOC_POS_SEC_IE];  // [RULE9]
            double_err_irq_enable_reg <= reg_wdata_i[`IOC_POS_DED_IE];  // [RULE9]
         end
         if (reg_be_i[1]) begin
            parity_reg <= reg_wdata_i[`IOC_POS_PARITY_LO +: 7]; // [RULE14]
         end
      end
   end

   ioc_sticky_flag u_fmt_flag (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .set_i     (cmd_format_err_i), // [RULE6]
      .clr_i     (clr_fmt),
      .flag_o    (cmd_format_err_flag)
   );

   ioc_sticky_flag u_crc_flag (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .set_i     (spi_check_err_i), // [RULE7]
      .clr_i     (clr_crc),
      .flag_o    (spi_check_err_flag)
   );

   ioc_sticky_flag u_sec_flag (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .set_i     (single_err_i), // [RULE10]
      .clr_i     (clr_sec),
      .flag_o    (single_err_flag)
   );

   ioc_sticky_flag u_ded_flag (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .set_i     (double_err_i), // [RULE10]
      .clr_i     (clr_ded),
      .flag_o    (double_err_flag)
   );

   // Only the most recent failure is kept; earlier ones are overwritten.
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         spi_check_value_reg <= '0;
      end else if (spi_check_err_i) begin
         spi_check_value_reg <= spi_check_value_i; // [RULE13]
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         failing_ram_address_reg <= '0;
      end else if (single_err_i || double_err_i) begin
         failing_ram_address_reg <= err_addr_i; // [RULE13]
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_pin
         ioc_pin_ctrl u_pin (
            .clk_sys_i   (clk_sys_i),
            .rstn_i      (rstn_i),
            .level_i     (pin_output_level_reg[gi]),
            .dir_i       (pin_direction_reg[gi]),
            .mode_i      (pin_mode_select_reg[gi]),
            .pin_i       (general_pin_i[gi]),
            .pin_o       (general_pin_o[gi]),
            .pin_oe_o    (general_pin_oe_o[gi]),
            .pin_level_o (pin_level_sync[gi])
         );
      end
   endgenerate

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         transceiver_standby_pin_o    <= 1'b0;
         transceiver_standby_pin_oe_o <= 1'b0;
      end else begin
         transceiver_standby_pin_oe_o <= standby_pin_ctrl_enable_reg;                      // [RULE2]
         transceiver_standby_pin_o    <= standby_pin_ctrl_enable_reg && standby_request_i; // [RULE2]
      end
   end

   // While correction is off the RAM takes the programmed parity, which allows fault injection.
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         ram_correction_enable_o  <= 1'b0;
         parity_override_enable_o <= 1'b1; // [RULE14] Correction is off at reset, so the override is live.
         parity_override_o        <= `IOC_RST_PARITY;
      end else begin
         ram_correction_enable_o  <= ram_correction_enable_reg;  // [RULE8]
         parity_override_enable_o <= !ram_correction_enable_reg; // [RULE14]
         parity_override_o        <= parity_reg;                 // [RULE14]
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= (cmd_format_err_flag && cmd_format_err_irq_enable_reg) || // [RULE15]
                  (spi_check_err_flag && spi_check_err_irq_enable_reg) ||
                  (single_err_flag && single_err_irq_enable_reg) ||          // [RULE9]
                  (double_err_flag && double_err_irq_enable_reg);
      end
   end

   // Unlisted bits stay zero because rdata_next starts cleared on every path.
   always_comb begin
      rdata_next = '0; // [RULE12]
      unique case (reg_idx_i)
         `IOC_IDX_PIN_IO: begin
            rdata_next[`IOC_POS_DIR0]    = pin_direction_reg[0];
            rdata_next[`IOC_POS_DIR1]    = pin_direction_reg[1];
            rdata_next[`IOC_POS_STBY_EN] = standby_pin_ctrl_enable_reg;
            rdata_next[`IOC_POS_LEVEL0]  = pin_output_level_reg[0];
            rdata_next[`IOC_POS_LEVEL1]  = pin_output_level_reg[1];
            rdata_next[`IOC_POS_PIN0_IN] = pin_level_sync[0];
            rdata_next[`IOC_POS_PIN1_IN] = pin_level_sync[1];
            rdata_next[`IOC_POS_MODE0]   = pin_mode_select_reg[0];
            rdata_next[`IOC_POS_MODE1]   = pin_mode_select_reg[1];
         end
         `IOC_IDX_CRC_STAT: begin
            rdata_next[`IOC_POS_CRC_VAL_LO +: 16] = spi_check_value_reg;
            rdata_next[`IOC_POS_CRC_FLAG]         = spi_check_err_flag;
            rdata_next[`IOC_POS_FMT_FLAG]         = cmd_format_err_flag;
            rdata_next[`IOC_POS_CRC_IE]           = spi_check_err_irq_enable_reg;
            rdata_next[`IOC_POS_FMT_IE]           = cmd_format_err_irq_enable_reg;
         end
         `IOC_IDX_ECC_CTRL: begin
            rdata_next[`IOC_POS_ECC_EN]         = ram_correction_enable_reg;
            rdata_next[`IOC_POS_SEC_IE]         = single_err_irq_enable_reg;
            rdata_next[`IOC_POS_DED_IE]         = double_err_irq_enable_reg;
            rdata_next[`IOC_POS_PARITY_LO +: 7] = parity_reg;
         end
         `IOC_IDX_ECC_STAT: begin
            rdata_next[`IOC_POS_SEC_FLAG]           = single_err_flag;
            rdata_next[`IOC_POS_DED_FLAG]           = double_err_flag;
            rdata_next[`IOC_POS_FAIL_ADDR_LO +: 12] = failing_ram_address_reg;
         end
         `IOC_IDX_PART_ID: begin
            rdata_next[`IOC_POS_REV_LO +: 4] = PART_REV; // [RULE11]
            rdata_next[`IOC_POS_ID_LO +: 4]  = PART_ID;  // [RULE11]
         end
         default: begin
            rdata_next = '0;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         reg_rdata_o  <= '0;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         reg_rdata_o  <= reg_rd_i ? rdata_next : '0;
      end
   end

   generate
      for (gi = 0; gi < 2; gi++) begin : g_pin_chk
         AST_PIN_LEVEL: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RULE1]
            1 |=> (general_pin_o[gi] == $past(pin_output_level_reg[gi])))
            else $error("pin level does not follow its latch");
         AST_PIN_DIR: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RULE3]
            (pin_mode_select_reg[gi] && pin_direction_reg[gi]) |=> !general_pin_oe_o[gi])
            else $error("input pin is being driven");
         AST_PIN_FORCE_OUT: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RULE4]
            !pin_mode_select_reg[gi] |=> general_pin_oe_o[gi])
            else $error("mode zero pin is not driven");
      end
   endgenerate

   AST_STBY_GATED: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RULE2]
      !standby_pin_ctrl_enable_reg |=> (!transceiver_standby_pin_o && !transceiver_standby_pin_oe_o))
      else $error("standby pin controlled while disabled");

   AST_FMT_STICKY: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RULE6]
      cmd_format_err_i |=> cmd_format_err_flag ##1 (cmd_format_err_flag || $past(clr_fmt)))
      else $error("format flag not set or lost without clear");

   AST_CRC_FLAG_VALUE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RULE7]
      spi_check_err_i |=> (spi_check_err_flag && spi_check_value_reg == $past(spi_check_value_i)))
      else $error("checksum flag or value not captured");

   AST_ECC_ENABLE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RULE8]
      1 |=> (ram_correction_enable_o == $past(ram_correction_enable_reg) &&
             parity_override_enable_o == !ram_correction_enable_o))
      else $error("correction enable or override mismatch");

   AST_ECC_FLAGS: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RULE10]
      (single_err_i || double_err_i) |=> ((single_err_flag || !$past(single_err_i)) &&
         (double_err_flag || !$past(double_err_i)) && failing_ram_address_reg == $past(err_addr_i)))
      else $error("error flag or failing address not captured");

   AST_ID_READ: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RULE11]
      (reg_rd_i && reg_idx_i == `IOC_IDX_PART_ID) |=> (reg_rvalid_o && reg_rdata_o == {24'h000000, PART_ID, PART_REV}))
      else $error("identity read value wrong");

   AST_RESERVED_ZERO: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RULE12]
      (reg_rd_i && reg_idx_i == `IOC_IDX_ECC_CTRL) |=> (reg_rdata_o[31:15] == 17'h00000 && reg_rdata_o[7:3] == 5'h00))
      else $error("reserved bits read non-zero");

   AST_IRQ: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RULE15]
      (single_err_flag && single_err_irq_enable_reg) |=> irq_o)
      else $error("enabled flag gave no interrupt");

   AST_IRQ_QUIET: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RULE9]
      !(cmd_format_err_irq_enable_reg || spi_check_err_irq_enable_reg || single_err_irq_enable_reg ||
        double_err_irq_enable_reg) |=> !irq_o)
      else $error("interrupt raised with all enables clear");
endmodule

// *** core/ioc_sticky_flag.sv ***
// Sticky flag set by hardware and cleared by software, where a set beats a clear.
`timescale 1ns/1ps
module ioc_sticky_flag (
   input  wire logic clk_sys_i,
   input  wire logic rstn_i,
   input  wire logic set_i,
   input  wire logic clr_i,
   output logic      flag_o
);
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         flag_o <= 1'b0;
      end else if (set_i) begin
         flag_o <= 1'b1;
      end else if (clr_i) begin
         flag_o <= 1'b0;
      end
   end
endmodule

// *** verif/ioc_host_model.sv ***
// Host-side model that issues register writes and reads to the bank.
`timescale 1ns/1ps
`include "ioc_defines.svh"
module ioc_host_model (
   input  wire logic               clk_sys_i,
   output logic                    reg_wr_o,
   output logic                    reg_rd_o,
   output ioc_pkg::ioc_reg_idx_t   reg_idx_o,
   output ioc_pkg::ioc_byte_en_t   reg_be_o,
   output ioc_pkg::ioc_word_t      reg_wdata_o,
   input  wire ioc_pkg::ioc_word_t reg_rdata_i,
   input  wire logic               reg_rvalid_i
);
   import ioc_pkg::*;
   initial begin
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      reg_idx_o   = 3'h0;
      reg_be_o    = 4'h0;
      reg_wdata_o = 32'h0;
   end
   // Fields are inverted after each request so the bank cannot lean on stale values.
   task automatic cycle(input logic wr, input ioc_reg_idx_t idx, input ioc_byte_en_t be, input ioc_word_t wd);
      @(posedge clk_sys_i);
      reg_wr_o    <= wr;
      reg_rd_o    <= ~wr;
      reg_idx_o   <= idx;
      reg_be_o    <= be;
      reg_wdata_o <= wd;
      @(posedge clk_sys_i);
      reg_wr_o    <= 1'b0;
      reg_rd_o    <= 1'b0;
      reg_idx_o   <= ~idx;
      reg_be_o    <= ~be;
      reg_wdata_o <= ~wd;
   endtask
   // Pin control takes one data byte per write, so wider writes are split lane by lane.
   task automatic write(input ioc_reg_idx_t idx, input ioc_byte_en_t be, input ioc_word_t wd);
      if (idx == `IOC_IDX_PIN_IO) begin
         for (int k = 0; k < 4; k++) begin
            if (be[k]) begin
               cycle(1'b1, idx, ioc_byte_en_t'(4'h1 << k), wd);
            end
         end
      end else begin
         cycle(1'b1, idx, be, wd);
      end
   endtask
   task automatic read(input ioc_reg_idx_t idx, output ioc_word_t rd, output logic ok);
      cycle(1'b0, idx, 4'h0, 32'h0);
      ok = 1'b0;
      rd = 32'h0;
      for (int n = 0; n < 4 && !ok; n++) begin
         #1;
         if (reg_rvalid_i === 1'b1) begin
            ok = 1'b1;
            rd = reg_rdata_i;
         end else begin
            @(posedge clk_sys_i);
         end
      end
   endtask
endmodule

// *** verif/tb_ioc_reg_bank.sv ***
// Self-checking bench for the pin, checksum error, RAM ECC and identity register bank.
`timescale 1ns/1ps
`include "ioc_defines.svh"
module tb_ioc_reg_bank;
   import ioc_pkg::*;
   localparam logic [3:0] ID_VAL  = 4'ha; // Arbitrary value.
   localparam logic [3:0] REV_VAL = 4'h6; // Arbitrary value.
   logic          clk_sys_i = 1'b0;
   logic          rstn_i, reg_wr, reg_rd, rvalid, irq, corr_en, par_en, stby_o, stby_oe;
   logic          fmt_err, chk_err, sec_err, ded_err, stby_req;
   logic [1:0]    pad, pin_in, pin_o, pin_oe, dir, lat, pm, oe;
   logic          stby, een, sie, die, cie, fie, crcf, fmtf, secf, dedf;
   ioc_reg_idx_t  idx;
   ioc_byte_en_t  be;
   ioc_word_t     wdata, rdata, seed, r, w, e;
   ioc_crc_t      chk_val, crc_cap;
   ioc_ram_addr_t err_addr, addr_cap;
   ioc_parity_t   par, parity;
   int            fails = 0;
   int            compares = 0;
   always #20 clk_sys_i = ~clk_sys_i;
   // A driven pad shows the bank's own level, otherwise the outside level.
   assign pin_in = (pin_oe & pin_o) | (~pin_oe & pad);
   ioc_host_model i_ioc_host_model (.clk_sys_i(clk_sys_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
      .reg_idx_o(idx), .reg_be_o(be), .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
   ioc_reg_bank #(.PART_ID(ID_VAL), .PART_REV(REV_VAL)) i_ioc_reg_bank (.clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_idx_i(idx), .reg_be_i(be),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .cmd_format_err_i(fmt_err),
      .spi_check_err_i(chk_err), .spi_check_value_i(chk_val), .single_err_i(sec_err),
      .double_err_i(ded_err), .err_addr_i(err_addr), .standby_request_i(stby_req),
      .general_pin_i(pin_in), .general_pin_o(pin_o), .general_pin_oe_o(pin_oe),
      .transceiver_standby_pin_o(stby_o), .transceiver_standby_pin_oe_o(stby_oe),
      .ram_correction_enable_o(corr_en), .parity_override_enable_o(par_en),
      .parity_override_o(par), .irq_o(irq));
   function automatic ioc_word_t nxt();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [1:0] f_oe();
      return ~(pm & dir);
   endfunction
   function automatic ioc_word_t f_pin();
      return {6'h0, pm, 6'h0, (f_oe() & lat) | (~f_oe() & pad), 6'h0, lat, 1'b0, stby, 4'h0, dir};
   endfunction
   function automatic logic f_irq();
      return (crcf & cie) | (fmtf & fie) | (secf & sie) | (dedf & die);
   endfunction
   task automatic chk(input string nm, input ioc_word_t seen, input ioc_word_t exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results();
      if (fails == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic rd_chk(input string nm, input ioc_reg_idx_t ri, input ioc_word_t exp);
      ioc_word_t v;
      logic      ok;
      i_ioc_host_model.read(ri, v, ok);
      if (ok !== 1'b1) begin
         chk("read answer", 32'h0, 32'h1);
         results();
      end else begin
         chk(nm, v, exp);
      end
   endtask
   // Reads every register, an unmapped index among them.
   task automatic rd_all(input int it);
      rd_chk("pin ctrl", `IOC_IDX_PIN_IO, f_pin());
      rd_chk("crc stat", `IOC_IDX_CRC_STAT, {6'h0, fie, cie, 6'h0, fmtf, crcf, crc_cap});
      rd_chk("ecc ctrl", `IOC_IDX_ECC_CTRL, {17'h0, parity, 5'h0, die, sie, een});
      rd_chk("ecc stat", `IOC_IDX_ECC_STAT, {4'h0, addr_cap, 13'h0, dedf, secf, 1'b0});
      rd_chk("part id", `IOC_IDX_PART_ID, {24'h0, ID_VAL, REV_VAL});
      rd_chk("unmapped", 3'h5 + ioc_reg_idx_t'(it % 3), 32'h0);
   endtask
   initial begin
      {rstn_i, fmt_err, chk_err, sec_err, ded_err, stby_req} = 6'h0;
      {chk_val, err_addr, pad} = 30'h0;
      seed = 32'hd;
      {dir, pm, lat, stby, een, sie, die, cie, fie} = 12'hf00;
      {crcf, fmtf, secf, dedf, parity, crc_cap, addr_cap} = 39'h0;
      repeat (5) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      rd_all(0);
      for (int it = 0; it < 40; it++) begin
         r = nxt();
         {fie, cie, parity, die, sie, een, pm, lat, stby, dir} = r[18:0];
         // The first pass forces mode zero with direction input, where the mode must win.
         if (it == 0) {pm, dir} = 4'h3;
         w = nxt();
         {w[25:24], w[9:8], w[6], w[1:0]} = {pm, lat, stby, dir};
         i_ioc_host_model.write(`IOC_IDX_PIN_IO, 4'hb, w);
         w = nxt();
         {w[14:8], w[2:0]} = {parity, die, sie, een};
         i_ioc_host_model.write(`IOC_IDX_ECC_CTRL, 4'hf, w);
         w = nxt();
         w[25:24] = {fie, cie};
         i_ioc_host_model.write(`IOC_IDX_CRC_STAT, 4'h8, w);
         i_ioc_host_model.write(`IOC_IDX_PART_ID, 4'hf, nxt());
         i_ioc_host_model.write(3'h5 + ioc_reg_idx_t'(it % 3), 4'hf, nxt());
         e = nxt();
         @(posedge clk_sys_i);
         {ded_err, sec_err, fmt_err, chk_err} <= e[3:0];
         {chk_val, err_addr, pad, stby_req} <= {e[31:16], e[15:4], e[6:5], e[4]};
         @(posedge clk_sys_i);
         {ded_err, sec_err, fmt_err, chk_err} <= 4'h0;
         if (e[0]) {crcf, crc_cap} = {1'b1, e[31:16]};
         fmtf = fmtf | e[1];
         secf = secf | e[2];
         dedf = dedf | e[3];
         if (e[2] | e[3]) addr_cap = e[15:4];
         repeat (3) @(posedge clk_sys_i);
         #1;
         oe = f_oe();
         chk("pin oe", {30'h0, pin_oe}, {30'h0, oe});
         chk("pin drive", {30'h0, pin_o & oe}, {30'h0, lat & oe});
         chk("standby", {30'h0, stby_o, stby_oe}, {30'h0, stby & e[4], stby});
         chk("ecc out", {23'h0, par, corr_en, par_en}, {23'h0, parity, een, ~een});
         chk("irq", {31'h0, irq}, {31'h0, f_irq()});
         rd_all(it);
         if (r[20]) begin
            i_ioc_host_model.write(`IOC_IDX_CRC_STAT, 4'h4, 32'h0);
            i_ioc_host_model.write(`IOC_IDX_ECC_STAT, 4'h1, 32'h0);
            {crcf, fmtf, secf, dedf} = 4'h0;
         end
         if (it == 1) begin
            // A single error in the very cycle of a clear must leave its flag set.
            fork
               i_ioc_host_model.write(`IOC_IDX_ECC_STAT, 4'h1, 32'h0);
               begin
                  @(posedge clk_sys_i);
                  {sec_err, err_addr} <= {1'b1, 12'h5a5};
                  @(posedge clk_sys_i);
                  sec_err <= 1'b0;
               end
            join
            {secf, dedf, addr_cap} = {1'b1, 1'b0, 12'h5a5};
            rd_chk("set wins", `IOC_IDX_ECC_STAT, {4'h0, addr_cap, 13'h0, dedf, secf, 1'b0});
         end
      end
      results();
   end
endmodule
